/* File: adc_mode_ctrl.sv */
// Operating-mode register, conversion-time registers and mode sequencer.
//
// Contract
// - A mode write clears status, raises done pin, aborts work, starts new mode.
// - One mode register at 0x38-0x3F; low three write address bits give channel.
// - Mode register is eight bits, read/write, resets to 0x00; the code reads it back at 0x38 only, 0x39-0x3F read 0x00.
// - Bits 7..5 select idle, cont, single, standby or four calibrations.
// - A newly written mode takes effect at once.
// - Channel picks first/single/calibrated channel or self-cal timing register.
// - Conversion-time bit 7 enables chopping; bits 6..0 are the filter word.
// - Chop, one channel: word times 128 plus 262 clocks; word 2 to 127.
// - Chop, several channels continuous: word times 128 plus 263 clocks.
// - No chop, one channel: word times 64 plus 213 clocks; word 3 to 127.
// - No chop, several channels continuous: word times 64 plus 214 clocks.
// - Clock-out disable stops the clock output and floats that pin.
// - External master clock keeps conversions running regardless of disable.
// - Crystal clock with disable set stops conversions; serial port still works.
// - Dump bit set makes a status read continue into the channel data.
// - Continuous read always gives status then data.
// - Continuous-read bit puts the serial port in continuous read mode.
// - Data-width bit picks 24-bit (set) or 16-bit (clear) channel data.
// - Clamp bit saturates out-of-range data; clear lets it follow input.
// - Eight conversion-time registers reset to 0x91.
// - Idle after reset; calibration or single conversion returns to idle.
// - Continuous mode converts each enabled channel in turn until changed.
// - Single conversion runs even on a disabled channel.
`timescale 1ns/1ps
`include "adc_mode_cfg.svh"
module adc_mode_ctrl
  import adc_mode_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire reg_req_s bus,
  input wire logic [7:0] chan_enable,
  input wire logic crystal_clock,
  input wire logic status_read,
  output logic [7:0] rdata,
  output logic conv_done_n,
  output logic [7:0] ready_bits,
  output logic status_clear,
  output logic [2:0] active_chan,
  output logic data_update,
  output logic [2:0] cal_kind,
  output logic cal_update,
  output logic clock_out_enable,
  output logic standby,
  output logic read_data_after_status,
  output logic continuous_read,
  output logic data_wide,
  output logic clamp_enable
);
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0][7:0] conv_time;
    logic [2:0] chan;
    logic [7:0] rdata;
    logic conv_done_n;
    logic [7:0] ready_bits;
    logic status_clear;
    logic data_update;
    logic cal_update;
    logic clock_out_enable;
    logic standby;
    logic dump_next;
  } ctl_s;
  ctl_s s_q;
  ctl_s s_d;
  conv_req_s creq;
  logic tmr_busy;
  logic tmr_done;
  logic mode_wr;
  logic time_wr;
  logic halted;
  op_mode_e cur_mode;
  logic chop_arm_q;
  logic [11:0] chop_cnt_q;

  // True for any address inside a span of eight registers at base.
  function automatic logic in_span(input logic [7:0] a, input logic [7:0] b);
    in_span = (a[7:3] == b[7:3]);
  endfunction

  // True when more than one channel is enabled.
  function automatic logic several(input logic [7:0] en);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++) begin
      n = n + 4'(en[i]);
    end
    several = (n > 4'h1);
  endfunction

  // Next enabled channel after c, wrapping; c itself if none other.
  function automatic logic [2:0] next_chan(input logic [2:0] c,
                                           input logic [7:0] en);
    logic [2:0] k;
    logic found;
    next_chan = c;
    found = 1'b0;
    for (int i = 1; i < 8; i++) begin
      k = c + 3'(i);
      if (!found && en[k]) begin
        next_chan = k;
        found = 1'b1;
      end
    end
  endfunction

  assign mode_wr = bus.we && in_span(bus.addr, `MODE_REG_BASE);
  assign time_wr = bus.we && in_span(bus.addr, `CONV_TIME_BASE);
  assign cur_mode = op_mode_e'(s_q.mode[`MODE_SEL_HI:`MODE_SEL_LO]);
  // A crystal stops with the clock output, an external clock does not.
  assign halted = crystal_clock && s_q.mode[`BIT_CLK_DIS];

  always_comb begin
    logic [2:0] wmode;
    wmode = bus.wdata[`MODE_SEL_HI:`MODE_SEL_LO];
    creq = '0;
    creq.chan = s_q.chan;
    creq.chop = s_q.conv_time[s_q.chan][`BIT_CHOP];
    creq.filter_word = s_q.conv_time[s_q.chan][6:0];
    creq.multi = (cur_mode == MODE_CONT) && several(chan_enable);
    if (mode_wr) begin
      // The new mode starts from the channel coded in the write address.
      creq.chan = bus.addr[2:0];
      creq.chop = s_q.conv_time[bus.addr[2:0]][`BIT_CHOP];
      creq.filter_word = s_q.conv_time[bus.addr[2:0]][6:0];
      creq.multi = (wmode == 3'(MODE_CONT)) && several(chan_enable);
      creq.start = (wmode != 3'(MODE_IDLE)) &&
        (wmode != 3'(MODE_STANDBY));
    end else if (tmr_done && cur_mode == MODE_CONT) begin
      creq.chan = next_chan(s_q.chan, chan_enable);
      creq.chop = s_q.conv_time[creq.chan][`BIT_CHOP];
      creq.filter_word = s_q.conv_time[creq.chan][6:0];
      creq.start = 1'b1;
    end
  end

  conv_timer u_timer (
    .clock(clock),
    .rst(rst),
    .abort(mode_wr),
    .hold(halted),
    .req(creq),
    .busy(tmr_busy),
    .done(tmr_done)
  );

  always_comb begin
    s_d = s_q;
    s_d.status_clear = 1'b0;
    s_d.data_update = 1'b0;
    s_d.cal_update = 1'b0;
    if (time_wr) begin
      s_d.conv_time[bus.addr[2:0]] = bus.wdata;
    end
    if (bus.re) begin
      s_d.rdata = 8'h00;
      // Only the base address returns the mode register.
      if (bus.addr == `MODE_REG_BASE) begin
        s_d.rdata = s_q.mode;
      end else if (in_span(bus.addr, `CONV_TIME_BASE)) begin
        s_d.rdata = s_q.conv_time[bus.addr[2:0]];
      end
    end
    // Status read runs on into data with dump set or in continuous read.
    s_d.dump_next = status_read &&
      (s_q.mode[`BIT_DUMP] || s_q.mode[`BIT_CONT_RD]);
    if (tmr_done) begin
      s_d.conv_done_n = 1'b0;
      if (cur_mode == MODE_CONT || cur_mode == MODE_SINGLE) begin
        s_d.ready_bits[s_q.chan] = 1'b1;
        s_d.data_update = 1'b1;
      end else begin
        s_d.ready_bits = 8'hFF;
        s_d.cal_update = 1'b1;
      end
      if (cur_mode == MODE_CONT) begin
        s_d.chan = creq.chan;
      end else begin
        s_d.mode[`MODE_SEL_HI:`MODE_SEL_LO] = 3'(MODE_IDLE);
      end
    end
    if (mode_wr) begin
      s_d.mode = bus.wdata;
      s_d.chan = bus.addr[2:0];
      s_d.ready_bits = 8'h00;
      s_d.status_clear = 1'b1;
      s_d.conv_done_n = 1'b1;
    end
    s_d.clock_out_enable = !s_d.mode[`BIT_CLK_DIS];
    s_d.standby = (s_d.mode[`MODE_SEL_HI:`MODE_SEL_LO] ==
      3'(MODE_STANDBY));
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      s_q.mode <= `MODE_RESET;
      s_q.conv_time <= {8{`CONV_TIME_RESET}};
      s_q.conv_done_n <= 1'b1;
      s_q.clock_out_enable <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata = s_q.rdata;
  assign conv_done_n = s_q.conv_done_n;
  assign ready_bits = s_q.ready_bits;
  assign status_clear = s_q.status_clear;
  assign active_chan = s_q.chan;
  assign data_update = s_q.data_update;
  assign cal_kind = s_q.mode[`MODE_SEL_HI:`MODE_SEL_LO];
  assign cal_update = s_q.cal_update;
  assign clock_out_enable = s_q.clock_out_enable;
  assign standby = s_q.standby;
  assign read_data_after_status = s_q.dump_next;
  assign continuous_read = s_q.mode[`BIT_CONT_RD];
  assign data_wide = s_q.mode[`BIT_WIDE];
  assign clamp_enable = s_q.mode[`BIT_CLAMP];

  chk_write_clears: assert property (@(posedge clock) disable iff (rst)
    mode_wr |=> conv_done_n && ready_bits == 8'h00 && status_clear)
    else $error("mode write did not clear status");
  chk_write_stores: assert property (@(posedge clock) disable iff (rst)
    mode_wr |=> active_chan == $past(bus.addr[2:0]))
    else $error("write channel not taken");
  chk_single_idle: assert property (@(posedge clock) disable iff (rst)
    tmr_done && cur_mode == MODE_SINGLE && !mode_wr
    |=> cal_kind == 3'h0 && !conv_done_n)
    else $error("single conversion did not return to idle");
  chk_cal_ready: assert property (@(posedge clock) disable iff (rst)
    tmr_done && cur_mode[2] && !mode_wr |=> ready_bits == 8'hFF)
    else $error("calibration did not set all ready bits");
  chk_clkout_gate: assert property (@(posedge clock) disable iff (rst)
    ##1 clock_out_enable == !$past(s_d.mode[`BIT_CLK_DIS]))
    else $error("clock output enable wrong");
  // Counts cycles of a default-setting chop conversion for the span check.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      chop_arm_q <= 1'b0;
      chop_cnt_q <= 12'h000;
    end else if (creq.start) begin
      chop_arm_q <= creq.chop && !creq.multi && creq.filter_word == 7'h11;
      chop_cnt_q <= 12'h000;
    end else begin
      chop_arm_q <= chop_arm_q && !halted && !tmr_done && !mode_wr;
      chop_cnt_q <= chop_cnt_q + 12'h001;
    end
  end

  chk_chop_span: assert property (@(posedge clock) disable iff (rst)
    chop_arm_q |->
    (tmr_done ? chop_cnt_q == 12'h985 : chop_cnt_q < 12'h985))
    else $error("chop conversion length wrong");
  chk_dump_follow: assert property (@(posedge clock) disable iff (rst)
    status_read && continuous_read |=> read_data_after_status)
    else $error("continuous read did not dump");
  chk_timer_busy: assert property (@(posedge clock) disable iff (rst)
    creq.start |=> tmr_busy)
    else $error("conversion did not start");
endmodule

/* File: adc_mode_cfg.svh */
// Offsets, field positions, reset values and timing constants of the mode control.
`ifndef ADC_MODE_CFG_SVH
`define ADC_MODE_CFG_SVH
`define MODE_REG_BASE 8'h38
`define MODE_REG_LAST 8'h3F
`define CONV_TIME_BASE 8'h30
`define CONV_TIME_LAST 8'h37
`define MODE_RESET 8'h00
`define CONV_TIME_RESET 8'h91
`define MODE_SEL_HI 7
`define MODE_SEL_LO 5
`define BIT_CLK_DIS 4
`define BIT_DUMP 3
`define BIT_CONT_RD 2
`define BIT_WIDE 1
`define BIT_CLAMP 0
`define BIT_CHOP 7
`define CHOP_STEP 18'h00080
`define CHOP_BASE_ONE 18'h00106
`define CHOP_BASE_MULTI 18'h00107
`define PLAIN_STEP 18'h00040
`define PLAIN_BASE_ONE 18'h000D5
`define PLAIN_BASE_MULTI 18'h000D6
`define CHOP_FW_MIN 7'h02
`define PLAIN_FW_MIN 7'h03
`endif

/* File: adc_mode_pkg.sv */
// Types shared by the mode and conversion-time control.
package adc_mode_pkg;
  typedef enum logic [2:0] {
    MODE_IDLE, MODE_CONT, MODE_SINGLE, MODE_STANDBY,
    MODE_SELF_ZERO, MODE_SELF_FULL, MODE_SYS_ZERO, MODE_SYS_FULL
  } op_mode_e;
  typedef struct packed {
    logic we;
    logic re;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;
  typedef struct packed {
    logic [2:0] chan;
    logic [6:0] filter_word;
    logic chop;
    logic multi;
    logic start;
  } conv_req_s;
endpackage

/* File: conv_timer.sv */
// Counts out one conversion or calibration in master-clock periods.
`timescale 1ns/1ps
`include "adc_mode_cfg.svh"
module conv_timer
  import adc_mode_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic abort,
  input wire logic hold,
  input wire conv_req_s req,
  output logic busy,
  output logic done
);
  typedef struct packed {
    logic busy;
    logic done;
    logic [17:0] left;
  } tmr_s;
  tmr_s s_q;
  tmr_s s_d;
  logic [17:0] span;
  logic [6:0] fw;

  always_comb begin
    fw = req.filter_word;
    if (req.chop) begin
      if (fw < `CHOP_FW_MIN) begin
        fw = `CHOP_FW_MIN;
      end
      // Duration is the filter word times the step plus the fixed base.
      span = 18'(fw) * `CHOP_STEP +
        (req.multi ? `CHOP_BASE_MULTI : `CHOP_BASE_ONE);
    end else begin
      if (fw < `PLAIN_FW_MIN) begin
        fw = `PLAIN_FW_MIN;
      end
      span = 18'(fw) * `PLAIN_STEP +
        (req.multi ? `PLAIN_BASE_MULTI : `PLAIN_BASE_ONE);
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    if (abort) begin
      s_d.busy = 1'b0;
    end
    if (req.start) begin
      s_d.busy = 1'b1;
      s_d.left = span - 18'h00001;
    end else if (s_q.busy && !abort && !hold) begin
      if (s_q.left == 18'h00001) begin
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
      end else begin
        s_d.left = s_q.left - 18'h00001;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign busy = s_q.busy;
  assign done = s_q.done;
endmodule

/* File: host_model.sv */
// Host controller model issuing register writes and reads.
`timescale 1ns/1ps
module host_model
  import adc_mode_pkg::*;
(
  input wire logic clock,
  output reg_req_s bus
);
  int gap = 0;
  initial bus = '{we: 1'b0, re: 1'b0, addr: 8'h00, wdata: 8'h00};
  // Released address and data lines show the inverse of the last value.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    repeat (gap + 1) @(posedge clock);
    bus <= '{we: w, re: ~w, addr: a, wdata: d};
    @(posedge clock);
    bus <= '{we: 1'b0, re: 1'b0, addr: ~a, wdata: ~d};
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 8'h00);
  endtask
endmodule

/* File: tb_top.sv */
// Self-checking testbench of the mode and conversion-time control.
`timescale 1ns/1ps
module tb_top;
  import adc_mode_pkg::*;
  logic clock, rst, crystal_clock, status_read, rd_v;
  logic [7:0] chan_enable, rdata, ready_bits, ct;
  logic conv_done_n, status_clear, data_update, cal_update, clock_out_enable;
  logic standby, read_data_after_status, continuous_read, data_wide;
  logic clamp_enable;
  logic [2:0] active_chan, cal_kind;
  reg_req_s bus;
  logic [7:0] exp_q[$];
  int fail_count, checked, cycles, n, seed;
  host_model host_u (.clock(clock), .bus(bus));
  adc_mode_ctrl dut_u (.clock, .rst, .bus, .chan_enable, .crystal_clock,
    .status_read, .rdata, .conv_done_n, .ready_bits, .status_clear,
    .active_chan, .data_update, .cal_kind, .cal_update, .clock_out_enable,
    .standby, .read_data_after_status, .continuous_read, .data_wide,
    .clamp_enable);
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task finish_test;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task check(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  // Read results are compared against the oldest expected note.
  always @(posedge clock) begin
    rd_v <= bus.re & ~rst;
    if (rd_v) begin
      if (exp_q.size() == 0)
        check(1'b0, "unexpected read");
      else
        check(rdata === exp_q.pop_front(), "read data");
    end
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      finish_test;
    end
  end
  function automatic int span(input logic [7:0] c, input int multi);
    return c[7] ? c[6:0] * 128 + 263 + multi : c[6:0] * 64 + 214 + multi;
  endfunction
  task rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host_u.rd(a);
  endtask
  task run_conv(input logic [7:0] a, input logic [7:0] d, input int e,
    input logic cal);
    host_u.wr(a, d);
    #1;
    check(status_clear === 1'b1 && conv_done_n === 1'b1, "write");
    n = 1;
    while (n < e + 20 && (cal ? cal_update : data_update) !== 1'b1) begin
      @(posedge clock);
      #1;
      n++;
    end
    check(n == e, "conversion time");
  endtask
  task next_update(input int e);
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (n < e + 20 && data_update !== 1'b1);
    check(n == e, "continuous interval");
  endtask
  task quiet(input int c);
    n = 0;
    repeat (c) begin
      @(posedge clock);
      #1;
      if (data_update === 1'b1 || cal_update === 1'b1)
        n++;
    end
    check(n == 0, "unexpected completion");
  endtask
  task pulse_status(input logic e);
    @(posedge clock);
    status_read <= 1'b1;
    @(posedge clock);
    status_read <= 1'b0;
    n = 0;
    repeat (3) begin
      #1;
      if (read_data_after_status === 1'b1)
        n++;
      @(posedge clock);
    end
    check((n != 0) == e, "status follow-on");
  endtask
  initial begin
    seed = 32'h0b35b9d8;
    rst = 1'b1;
    chan_enable = 8'h00;
    crystal_clock = 1'b0;
    status_read = 1'b0;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    rd(8'h38, 8'h00);
    for (int i = 0; i < 8; i++)
      rd(8'h30 + 8'(i), 8'h91);
    check(conv_done_n === 1'b1 && clock_out_enable === 1'b1, "reset");
    $display("test reset done");
    host_u.wr(8'h32, 8'h82);
    host_u.gap = 2;
    rd(8'h32, 8'h82);
    run_conv(8'h3A, 8'h40, span(8'h82, 0), 0);
    check(active_chan === 3'd2 && ready_bits[2] === 1'b1, "chan");
    check(conv_done_n === 1'b0, "done pin");
    rd(8'h38, 8'h00);
    host_u.wr(8'h33, 8'h03);
    run_conv(8'h3B, 8'h40, span(8'h03, 0), 0);
    ct = 8'h80 | 8'(2 + ($unsigned($random(seed)) % 126));
    host_u.wr(8'h31, ct);
    run_conv(8'h39, 8'h40, span(ct, 0), 0);
    run_conv(8'h3C, 8'h40, span(8'h91, 0), 0);
    $display("test single done");
    chan_enable <= 8'h05;
    host_u.wr(8'h30, 8'h03);
    run_conv(8'h38, 8'h20, span(8'h03, 1), 0);
    check(ready_bits[0] === 1'b1 && active_chan === 3'd2, "first chan");
    run_conv(8'h3A, 8'h20, span(8'h82, 1), 0);
    check(active_chan === 3'd0, "next chan");
    next_update(span(8'h03, 1) - 1);
    check(ready_bits[0] === 1'b1 && active_chan === 3'd2, "turn");
    host_u.wr(8'h38, 8'h00);
    quiet(600);
    $display("test continuous done");
    host_u.wr(8'h38, 8'h1F);
    #1;
    check(clock_out_enable === 1'b0 && continuous_read === 1'b1, "opt");
    check(data_wide === 1'b1 && clamp_enable === 1'b1, "opt");
    rd(8'h38, 8'h1F);
    rd(8'h3B, 8'h00);
    pulse_status(1'b1);
    host_u.wr(8'h38, 8'h04);
    pulse_status(1'b1);
    host_u.wr(8'h38, 8'h00);
    pulse_status(1'b0);
    $display("test options done");
    crystal_clock <= 1'b1;
    host_u.wr(8'h3A, 8'h50);
    quiet(600);
    crystal_clock <= 1'b0;
    run_conv(8'h3A, 8'h50, span(8'h82, 0), 0);
    check(clock_out_enable === 1'b0, "clock out");
    $display("test clock done");
    for (int k = 4; k < 8; k++) begin
      run_conv(8'h38, 8'(k << 5), span(8'h03, 0), 1);
      check(ready_bits === 8'hFF, "cal ready");
      rd(8'h38, 8'h00);
    end
    host_u.wr(8'h38, 8'h60);
    #1;
    check(standby === 1'b1, "standby");
    $display("test modes done");
    finish_test;
  end
endmodule
